/* hw/cci_consts.vh */
// constants for the channel change interrupt status block
// assumes an 8-bit register address and 8-bit register data
`ifndef CCI_CONSTS_VH
`define CCI_CONSTS_VH

// data and address widths of the control port
`define CCI_DATA_W          8
`define CCI_ADDR_W          8
`define CCI_EVT_W           4

// per-channel register offsets
`define CCI_OFS_EN_CH0      8'h01
`define CCI_OFS_STAT_CH0    8'h02
`define CCI_OFS_ALARM_CH0   8'h03
`define CCI_OFS_EN_CH1      8'h09
`define CCI_OFS_STAT_CH1    8'h0a
`define CCI_OFS_ALARM_CH1   8'h0b

// block-level interrupt registers
`define CCI_OFS_IRQ_STAT    8'h10
`define CCI_OFS_IRQ_MASK    8'h11

// event bit positions, shared by status, enable and alarm registers
`define CCI_BIT_FIFO_LIMIT  3
`define CCI_BIT_LOCK_LOSS   2
`define CCI_BIT_SIGNAL_LOSS 1
`define CCI_BIT_DRIVE_MON   0

// field of each channel inside the block interrupt registers
`define CCI_IRQ_CH0_LSB     0
`define CCI_IRQ_CH1_LSB     4

// reset values
`define CCI_RST_BYTE        8'h00
`define CCI_RST_EVT         4'h0
`define CCI_UNMAPPED_DATA   8'h00

`endif

/* hw/cci_channel.v */
// one channel of change-event capture: edge detect, enable gate, sticky
// clear-on-read status and the live condition levels
// assumes condition inputs are synchronous to i_clock
`timescale 1ns/100ps
`include "cci_consts.vh"

module cci_channel (
	input  wire                  i_clock,
	input  wire                  i_resetn,
	input  wire [`CCI_EVT_W-1:0] i_cond,
	input  wire [`CCI_EVT_W-1:0] i_enable,
	input  wire                  i_clear_on_read,
	output wire [`CCI_EVT_W-1:0] o_status,
	output wire [`CCI_EVT_W-1:0] o_live,
	output wire [`CCI_EVT_W-1:0] o_event
);

	reg  [`CCI_EVT_W-1:0] cond_q;
	reg  [`CCI_EVT_W-1:0] status_q;
	reg  [`CCI_EVT_W-1:0] status_d;
	wire [`CCI_EVT_W-1:0] change;

	// --------------------------------------------------------------
	// change detection
	// --------------------------------------------------------------
	// declare and clear both count: any difference from last cycle
	assign change  = cond_q ^ i_cond;
	assign o_event = change & i_enable;

	// a new event wins over the read clear so it is never dropped
	always @* begin
		status_d = status_q;
		if (i_clear_on_read) begin
			status_d = `CCI_RST_EVT;
		end
		status_d = status_d | o_event;
	end

	// sticky status and the last seen condition levels
	always @(posedge i_clock) begin
		if (!i_resetn) begin
			cond_q   <= `CCI_RST_EVT;
			status_q <= `CCI_RST_EVT;
		end else begin
			cond_q   <= i_cond;
			status_q <= status_d;
		end
	end

	assign o_status = status_q;
	assign o_live   = cond_q;

endmodule

/* hw/cci_top.v */
// top of the channel change interrupt status block: control port,
// per-channel enable, status and alarm registers, block interrupt
// assumes a single 10 MHz clock and conditions synchronous to it
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`include "cci_consts.vh"

// Function
// - channel 0 status at 0x02, channel 1 at 0x0a, own events only
// - bit 3 flags a fifo limit alarm change since last read
// - bit 2 flags a receive lock loss change since last read
// - bit 1 flags a receive signal loss change since last read
// - bit 0 flags a transmit drive monitor change since last read
// - reading the status register clears all four event bits, except a bit with a new event in the same cycle
// - live condition levels readable in alarm register, same bit order
// - both declaring and clearing a condition make a change event
// - each change event gated by its enable bit, reset disabled
module cci_top (
	input  wire                   i_clock,
	input  wire                   i_resetn,
	input  wire [`CCI_ADDR_W-1:0] i_addr,
	input  wire [`CCI_DATA_W-1:0] i_wdata,
	input  wire                   i_wr,
	input  wire                   i_rd,
	input  wire                   i_ch0_fifo_limit_alarm,
	input  wire                   i_ch0_receive_lock_loss,
	input  wire                   i_ch0_receive_signal_loss,
	input  wire                   i_ch0_transmit_drive_monitor,
	input  wire                   i_ch1_fifo_limit_alarm,
	input  wire                   i_ch1_receive_lock_loss,
	input  wire                   i_ch1_receive_signal_loss,
	input  wire                   i_ch1_transmit_drive_monitor,
	output wire [`CCI_DATA_W-1:0] o_rdata,
	output wire                   o_irq
);

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	reg  [`CCI_DATA_W-1:0] rdata_q;
	reg  [`CCI_DATA_W-1:0] rdata_d;
	reg                    irq_q;
	reg                    irq_d;

	reg  [`CCI_EVT_W-1:0]  enable_ch0_q;
	reg  [`CCI_EVT_W-1:0]  enable_ch1_q;
	reg  [`CCI_DATA_W-1:0] irq_status_q;
	reg  [`CCI_DATA_W-1:0] irq_status_d;
	reg  [`CCI_DATA_W-1:0] irq_mask_q;

	wire [`CCI_EVT_W-1:0]  cond_ch0;
	wire [`CCI_EVT_W-1:0]  cond_ch1;
	wire [`CCI_EVT_W-1:0]  status_ch0;
	wire [`CCI_EVT_W-1:0]  status_ch1;
	wire [`CCI_EVT_W-1:0]  live_ch0;
	wire [`CCI_EVT_W-1:0]  live_ch1;
	wire [`CCI_EVT_W-1:0]  event_ch0;
	wire [`CCI_EVT_W-1:0]  event_ch1;
	wire [`CCI_DATA_W-1:0] event_all;

	wire                   hit_en_ch0;
	wire                   hit_stat_ch0;
	wire                   hit_en_ch1;
	wire                   hit_stat_ch1;
	wire                   hit_irq_stat;
	wire                   hit_irq_mask;

	wire                   wr_en_ch0;
	wire                   wr_en_ch1;
	wire                   wr_irq_stat;
	wire                   wr_irq_mask;
	wire                   rd_clear_ch0;
	wire                   rd_clear_ch1;

	// --------------------------------------------------------------
	// condition bundling
	// --------------------------------------------------------------
	// each channel keeps its own inputs so events never cross over
	assign cond_ch0[`CCI_BIT_FIFO_LIMIT]  = i_ch0_fifo_limit_alarm;
	assign cond_ch0[`CCI_BIT_LOCK_LOSS]   = i_ch0_receive_lock_loss;
	assign cond_ch0[`CCI_BIT_SIGNAL_LOSS] = i_ch0_receive_signal_loss;
	assign cond_ch0[`CCI_BIT_DRIVE_MON]   = i_ch0_transmit_drive_monitor;

	assign cond_ch1[`CCI_BIT_FIFO_LIMIT]  = i_ch1_fifo_limit_alarm;
	assign cond_ch1[`CCI_BIT_LOCK_LOSS]   = i_ch1_receive_lock_loss;
	assign cond_ch1[`CCI_BIT_SIGNAL_LOSS] = i_ch1_receive_signal_loss;
	assign cond_ch1[`CCI_BIT_DRIVE_MON]   = i_ch1_transmit_drive_monitor;

	// --------------------------------------------------------------
	// address decode
	// --------------------------------------------------------------
	// full 8-bit compare; aliases would let a stray read clear status
	assign hit_en_ch0    = (i_addr == `CCI_OFS_EN_CH0);
	assign hit_stat_ch0  = (i_addr == `CCI_OFS_STAT_CH0);
	assign hit_en_ch1    = (i_addr == `CCI_OFS_EN_CH1);
	assign hit_stat_ch1  = (i_addr == `CCI_OFS_STAT_CH1);
	assign hit_irq_stat  = (i_addr == `CCI_OFS_IRQ_STAT);
	assign hit_irq_mask  = (i_addr == `CCI_OFS_IRQ_MASK);

	// write strobes; status and alarm registers ignore writes
	assign wr_en_ch0   = i_wr & hit_en_ch0;
	assign wr_en_ch1   = i_wr & hit_en_ch1;
	assign wr_irq_stat = i_wr & hit_irq_stat;
	assign wr_irq_mask = i_wr & hit_irq_mask;

	// a read of a status register clears it at the same edge that
	// captures the old value into the read data flop
	assign rd_clear_ch0 = i_rd & hit_stat_ch0;
	assign rd_clear_ch1 = i_rd & hit_stat_ch1;

	// --------------------------------------------------------------
	// channel instances
	// --------------------------------------------------------------
	// channel 0 capture
	cci_channel u_ch0 (
		.i_clock         (i_clock),
		.i_resetn        (i_resetn),
		.i_cond          (cond_ch0),
		.i_enable        (enable_ch0_q),
		.i_clear_on_read (rd_clear_ch0),
		.o_status        (status_ch0),
		.o_live          (live_ch0),
		.o_event         (event_ch0)
	);

	// channel 1 capture
	cci_channel u_ch1 (
		.i_clock         (i_clock),
		.i_resetn        (i_resetn),
		.i_cond          (cond_ch1),
		.i_enable        (enable_ch1_q),
		.i_clear_on_read (rd_clear_ch1),
		.o_status        (status_ch1),
		.o_live          (live_ch1),
		.o_event         (event_ch1)
	);

	// --------------------------------------------------------------
	// enable registers
	// --------------------------------------------------------------
	// only the low nibble is stored; upper bits are not implemented
	always @(posedge i_clock) begin
		if (!i_resetn) begin
			enable_ch0_q <= `CCI_RST_EVT;
			enable_ch1_q <= `CCI_RST_EVT;
		end else begin
			if (wr_en_ch0) begin
				enable_ch0_q <= i_wdata[`CCI_EVT_W-1:0];
			end
			if (wr_en_ch1) begin
				enable_ch1_q <= i_wdata[`CCI_EVT_W-1:0];
			end
		end
	end

	// --------------------------------------------------------------
	// block interrupt status and mask
	// --------------------------------------------------------------
	// events of both channels, channel 0 in the low nibble
	assign event_all = {event_ch1, event_ch0};

	// write one clears, but a same-cycle event keeps its bit set
	always @* begin
		irq_status_d = irq_status_q;
		if (wr_irq_stat) begin
			irq_status_d = irq_status_q & ~i_wdata;
		end
		irq_status_d = irq_status_d | event_all;
	end

	// sticky status and software mask
	always @(posedge i_clock) begin
		if (!i_resetn) begin
			irq_status_q <= `CCI_RST_BYTE;
			irq_mask_q   <= `CCI_RST_BYTE;
		end else begin
			irq_status_q <= irq_status_d;
			if (wr_irq_mask) begin
				irq_mask_q <= i_wdata;
			end
		end
	end

	// level output from the next state, so it rises with the status bit
	always @* begin
		irq_d = |(irq_status_d & irq_mask_q);
	end

	// registered interrupt line
	always @(posedge i_clock) begin
		if (!i_resetn) begin
			irq_q <= 1'h0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// --------------------------------------------------------------
	// read path
	// --------------------------------------------------------------
	// data appear only in the cycle after the read strobe; the status
	// value shown is the one before the read clears it
	always @* begin
		rdata_d = `CCI_UNMAPPED_DATA;
		if (i_rd) begin
			case (i_addr)
				`CCI_OFS_EN_CH0: begin
					rdata_d = {4'h0, enable_ch0_q};
				end
				`CCI_OFS_STAT_CH0: begin
					rdata_d = {4'h0, status_ch0};
				end
				`CCI_OFS_ALARM_CH0: begin
					rdata_d = {4'h0, live_ch0};
				end
				`CCI_OFS_EN_CH1: begin
					rdata_d = {4'h0, enable_ch1_q};
				end
				`CCI_OFS_STAT_CH1: begin
					rdata_d = {4'h0, status_ch1};
				end
				`CCI_OFS_ALARM_CH1: begin
					rdata_d = {4'h0, live_ch1};
				end
				`CCI_OFS_IRQ_STAT: begin
					rdata_d = irq_status_q;
				end
				`CCI_OFS_IRQ_MASK: begin
					rdata_d = irq_mask_q;
				end
				default: begin
					rdata_d = `CCI_UNMAPPED_DATA;
				end
			endcase
		end
	end

	// read data flop, zero outside the answer cycle
	always @(posedge i_clock) begin
		if (!i_resetn) begin
			rdata_q <= `CCI_RST_BYTE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign o_rdata = rdata_q;
	assign o_irq   = irq_q;

endmodule

/* dv/cci_line_src.sv */
// line-side condition source: eight condition levels
// assumes the bench pulses i_flip for one cycle to toggle levels
`timescale 1ns/100ps
module cci_line_src (
	input  wire       i_clock,
	input  wire [7:0] i_flip,
	output reg  [7:0] o_cond
);
	// levels move only on an edge, so the block sees clean steps
	initial o_cond = 8'h00;
	always @(posedge i_clock) begin
		o_cond <= o_cond ^ i_flip;
	end
endmodule

/* dv/cci_top_assertions.sv */
// checker for cci_top: register port and interrupt relations
// assumes one clock and the synchronous active-low reset
`timescale 1ns/100ps
`include "cci_consts.vh"
module cci_top_assertions (
	input wire                   i_clock,
	input wire                   i_resetn,
	input wire [`CCI_ADDR_W-1:0] i_addr,
	input wire [`CCI_DATA_W-1:0] i_wdata,
	input wire                   i_wr,
	input wire                   i_rd,
	input wire                   i_ch0_fifo_limit_alarm,
	input wire                   i_ch1_transmit_drive_monitor,
	input wire [`CCI_DATA_W-1:0] o_rdata,
	input wire                   o_irq
);
	// ----
	// relations
	// ----
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	// a status read of either channel
	wire rd_st = i_rd && (i_addr == 8'h02 || i_addr == 8'h0a);
	AST_RST_ZERO: assert property ($rose(i_resetn) |-> o_rdata == 8'h00 && !o_irq)
		else $error("outputs not idle after reset");
	AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data outside read slot");
	AST_STAT_HI: assert property (rd_st |=> o_rdata[7:4] == 4'h0)
		else $error("unused status bits set");
	AST_RD_CLEAR: assert property (i_rd && i_addr == 8'h02 && $stable(i_ch0_fifo_limit_alarm)
		##1 i_rd && i_addr == 8'h02 && $stable(i_ch0_fifo_limit_alarm) |=> !o_rdata[3])
		else $error("status bit survived read");
	AST_ALARM_CH0: assert property (i_rd && i_addr == 8'h03 |=>
		o_rdata[3] == $past(i_ch0_fifo_limit_alarm, 2)) else $error("alarm ch0 wrong");
	AST_ALARM_CH1: assert property (i_rd && i_addr == 8'h0b |=>
		o_rdata[0] == $past(i_ch1_transmit_drive_monitor, 2)) else $error("alarm ch1 wrong");
	AST_UNMAPPED: assert property (i_rd && i_addr == 8'h20 |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	// the mask write edge still uses the old mask, hence two cycles
	AST_MASK_OFF: assert property (i_wr && i_addr == 8'h11 && i_wdata == 8'h00 |-> ##2 !o_irq)
		else $error("irq high with mask clear");
	C_RD_ST: cover property (rd_st);
	C_IRQ: cover property ($rose(o_irq));
	C_ALARM: cover property (i_rd && i_addr == 8'h0b);
endmodule

bind cci_top cci_top_assertions u_chk (
	.i_clock(i_clock),
	.i_resetn(i_resetn),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.i_ch0_fifo_limit_alarm(i_ch0_fifo_limit_alarm),
	.i_ch1_transmit_drive_monitor(i_ch1_transmit_drive_monitor),
	.o_rdata(o_rdata),
	.o_irq(o_irq)
);

/* dv/cci_tb_top.sv */
// self-checking bench for cci_top: reads, events, interrupt
// assumes the line source model drives all condition inputs
`timescale 1ns/100ps
module channel_change_interrupt_status_tb_top;
	reg         i_clock;
	reg         i_resetn;
	reg  [7:0]  i_addr;
	reg  [7:0]  i_wdata;
	reg         i_wr;
	reg         i_rd;
	reg  [7:0]  flip;
	wire [7:0]  c;
	wire [7:0]  o_rdata;
	wire        o_irq;
	integer     err_total;
	integer     cmp_count;
	integer     i;
	integer     cyc = 0;
	reg  [71:0] amap = 72'h01_02_03_09_0a_0b_10_11_20;
	cci_line_src SRC (.i_clock(i_clock), .i_flip(flip), .o_cond(c));
	cci_top DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_ch0_fifo_limit_alarm(c[3]), .i_ch0_receive_lock_loss(c[2]),
		.i_ch0_receive_signal_loss(c[1]), .i_ch0_transmit_drive_monitor(c[0]),
		.i_ch1_fifo_limit_alarm(c[7]), .i_ch1_receive_lock_loss(c[6]),
		.i_ch1_receive_signal_loss(c[5]), .i_ch1_transmit_drive_monitor(c[4]),
		.o_rdata(o_rdata), .o_irq(o_irq));
	// ----
	// clock, timeout, tasks
	// ----
	initial begin
		i_clock = 1'h0;
		forever #50 i_clock = ~i_clock;
	end
	// the tests need about 140 cycles; a hang is cut well above that
	always @(posedge i_clock) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			err_total = err_total + 1;
			complete_run;
		end
	end
	task complete_run;
		begin
			if (err_total == 0 && cmp_count > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("unexpected %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge i_clock);
			i_wr <= 1'h1;
			i_addr <= a;
			i_wdata <= d;
			@(posedge i_clock);
			i_wr <= 1'h0;
		end
	endtask
	// data stand only in the cycle after the strobe, so look there
	task rd(input [7:0] a, input [7:0] exp);
		begin
			@(posedge i_clock);
			i_rd <= 1'h1;
			i_addr <= a;
			@(posedge i_clock);
			i_rd <= 1'h0;
			#1;
			chk(o_rdata, exp);
		end
	endtask
	task tog(input [7:0] v);
		begin
			@(posedge i_clock);
			flip <= v;
			@(posedge i_clock);
			flip <= 8'h00;
		end
	endtask
	task irq(input exp);
		begin
			@(posedge i_clock);
			#1;
			chk({7'h00, o_irq}, {7'h00, exp});
		end
	endtask
	// ----
	// tests
	// ----
	initial begin
		err_total = 0;
		cmp_count = 0;
		i_resetn = 1'h0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_wr = 1'h0;
		i_rd = 1'h0;
		flip = 8'h00;
		repeat (16) @(posedge i_clock);
		i_resetn <= 1'h1;
		for (i = 0; i < 9; i = i + 1)
			rd(amap[8*i +: 8], 8'h00);
		tog(8'h0f);
		rd(8'h02, 8'h00);
		wr(8'h01, 8'hff);
		wr(8'h09, 8'h0f);
		rd(8'h01, 8'h0f);
		// ch0 bits fall, ch1 bits rise, one at a time
		for (i = 0; i < 4; i = i + 1) begin
			tog(8'h01 << i);
			rd(8'h02, 8'h01 << i);
			rd(8'h02, 8'h00);
			tog(8'h10 << i);
			rd(8'h0a, 8'h01 << i);
			rd(8'h02, 8'h00);
		end
		tog(8'h0a);
		rd(8'h03, 8'h0a);
		rd(8'h0b, 8'h0f);
		rd(8'h02, 8'h0a);
		// events land on the edge of the first of three back-to-back reads;
		// bit 3 then stays put, so the middle read must clear it
		@(posedge i_clock);
		flip <= 8'h09;
		@(posedge i_clock);
		flip <= 8'h00;
		i_rd <= 1'h1;
		i_addr <= 8'h02;
		@(posedge i_clock);
		#1;
		chk(o_rdata, 8'h00);
		@(posedge i_clock);
		#1;
		chk(o_rdata, 8'h09);
		@(posedge i_clock);
		i_rd <= 1'h0;
		#1;
		chk(o_rdata, 8'h00);
		// interrupt: clear, mask, raise, mask off, clear one bit
		wr(8'h10, 8'hff);
		rd(8'h10, 8'h00);
		wr(8'h11, 8'h01);
		tog(8'h02);
		irq(1'h0);
		tog(8'h01);
		irq(1'h1);
		rd(8'h02, 8'h03);
		irq(1'h1);
		wr(8'h11, 8'h00);
		irq(1'h0);
		wr(8'h11, 8'h01);
		irq(1'h1);
		wr(8'h10, 8'h01);
		irq(1'h0);
		rd(8'h10, 8'h02);
		// ch1 events land in the upper nibble of the block status
		tog(8'h10);
		rd(8'h10, 8'h12);
		wr(8'h11, 8'h10);
		irq(1'h1);
		complete_run;
	end
endmodule
